// ### include/ipd_defines.svh
// register map, field positions, reset values and timing counts
`ifndef IPD_DEFINES_SVH
`define IPD_DEFINES_SVH
`define IPD_OFF_EDGE_SEL 16'hF1C0
`define IPD_OFF_SYS_CFG 16'hF1C4
`define IPD_OFF_CHAN_IRQ 16'hF1C8
`define IPD_OFF_STATUS 16'hF1CC
`define IPD_RST_EDGE_SEL 16'h0000
`define IPD_RST_SYS_CFG 16'h0000
`define IPD_RST_PWR 5'h1C
`define IPD_SLEEP_CFG_BIT 5
`define IPD_CODE_OFF 2'h0
`define IPD_CODE_RISE 2'h1
`define IPD_CODE_FALL 2'h2
`define IPD_CODE_BOTH 2'h3
`define IPD_CLK_PERIOD_NS 25
`define IPD_WAKE_MIN_NS 40
`define IPD_WAKE_MIN_CYC \
  ((`IPD_WAKE_MIN_NS + `IPD_CLK_PERIOD_NS - 1) / `IPD_CLK_PERIOD_NS)
`endif

// ### include/ipd_pkg.sv
// types shared by the idle and power down controller
package ipd_pkg;
  typedef enum logic [2:0] {
    ST_RUN, ST_WAIT_BUS, ST_IDLE, ST_PD_PROT, ST_PD_INT, ST_WAKE_WAIT,
    ST_RESUME, ST_ISR
  } ipd_state_t;

  typedef struct packed {
    logic idleInstr;
    logic sleepAllInstr;
    logic busBusy;
    logic readyEnabled;
    logic readyAckLast;
    logic irqRequest;
    logic eventXferOk;
    logic eventXferFail;
  } ipd_cpu_t;

  typedef struct packed {
    logic cpuRun;
    logic periphRun;
    logic oscOn;
    logic capPullDown;
    logic capPullUp;
  } ipd_power_t;

  typedef struct packed {
    ipd_state_t st;
    logic pendPd;
    logic [15:0] edgeSel;
    logic sleepCfg;
    logic [7:0] irqEnable;
    logic [7:0] irqFlag;
    logic [7:0] wakeS1;
    logic [7:0] wakeS2;
    logic [7:0] wakePrev;
    logic [7:0] entryLvl;
    logic [7:0] wakeChan;
    logic [1:0] holdCnt;
    logic nmiS1;
    logic nmiS2;
    logic capS1;
    logic capS2;
    ipd_power_t pwr;
    logic refused;
    logic stepNext;
    logic isrCall;
    logic pready;
    logic [31:0] prdata;
  } ipd_regs_t;
endpackage

// ### logic/ipd_power_ctrl.sv
// idle and power down sequencing with its apb register slave
`timescale 1ns/1ps
`include "ipd_defines.svh"
module ipd_power_ctrl #(
  parameter int NPINS = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ipd_pkg::ipd_cpu_t cpuIn,
  input wire logic nmiPinN,
  input wire logic [7:0] fastWakePin,
  input wire logic capBelowThr,
  output ipd_pkg::ipd_power_t pwrOut,
  output logic entryRefused,
  output logic stepNext,
  output logic isrCall,
  output logic [7:0] irqFlag
);
  localparam logic [1:0] HOLD_CYC = 2'(`IPD_WAKE_MIN_CYC);

  ipd_pkg::ipd_regs_t s_r;
  ipd_pkg::ipd_regs_t s_nxt;
  logic [7:0] lvl;
  logic [7:0] inactive;
  logic [7:0] hit;
  logic [7:0] edgeHit;
  logic [1:0] code;
  logic allInactive;
  logic entryOk;
  logic [7:0] setMask;
  logic wr;
  logic rd;

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = 1'b0;
  assign pwrOut = s_r.pwr;
  assign entryRefused = s_r.refused;
  assign stepNext = s_r.stepNext;
  assign isrCall = s_r.isrCall;
  assign irqFlag = s_r.irqFlag;

  always_comb begin
    s_nxt = s_r;
    lvl = s_r.wakeS2;
    inactive = '0;
    hit = '0;
    edgeHit = '0;
    code = 2'h0;
    setMask = '0;
    s_nxt.wakeS1 = fastWakePin;
    s_nxt.wakeS2 = s_r.wakeS1;
    s_nxt.wakePrev = s_r.wakeS2;
    s_nxt.nmiS1 = nmiPinN;
    s_nxt.nmiS2 = s_r.nmiS1;
    s_nxt.capS1 = capBelowThr;
    s_nxt.capS2 = s_r.capS1;
    s_nxt.refused = 1'b0;
    s_nxt.stepNext = 1'b0;
    s_nxt.isrCall = 1'b0;
    s_nxt.pready = 1'b0;
    for (int i = 0; i < NPINS; i++) begin
      code = s_r.edgeSel[2*i +: 2];
      // level view for power down, edge view otherwise
      case (code)
        `IPD_CODE_RISE: begin
          inactive[i] = ~lvl[i];
          hit[i] = lvl[i];
          edgeHit[i] = lvl[i] & ~s_r.wakePrev[i];
        end
        `IPD_CODE_FALL: begin
          inactive[i] = lvl[i];
          hit[i] = ~lvl[i];
          edgeHit[i] = ~lvl[i] & s_r.wakePrev[i];
        end
        `IPD_CODE_BOTH: begin
          // either level may enter; any change from it wakes
          inactive[i] = 1'b1;
          hit[i] = lvl[i] ^ s_r.entryLvl[i];
          edgeHit[i] = lvl[i] ^ s_r.wakePrev[i];
        end
        default: begin
          inactive[i] = 1'b1;
        end
      endcase
    end
    allInactive = &inactive;
    // ready enabled but not seen on the last access blocks entry
    entryOk = ~(cpuIn.readyEnabled & ~cpuIn.readyAckLast);

    case (s_r.st)
      ipd_pkg::ST_RUN: begin
        setMask = edgeHit;
        if (cpuIn.sleepAllInstr) begin
          s_nxt.pendPd = 1'b1;
          s_nxt.st = ipd_pkg::ST_WAIT_BUS;
        end else if (cpuIn.idleInstr) begin
          s_nxt.pendPd = 1'b0;
          s_nxt.st = ipd_pkg::ST_WAIT_BUS;
        end
      end
      ipd_pkg::ST_WAIT_BUS: begin
        setMask = edgeHit;
        // outstanding bus cycles finish before any entry
        if (!cpuIn.busBusy) begin
          s_nxt.st = ipd_pkg::ST_RUN;
          if (!entryOk) begin
            s_nxt.refused = 1'b1;
          end else if (!s_r.pendPd) begin
            s_nxt.st = ipd_pkg::ST_IDLE;
            s_nxt.pwr.cpuRun = 1'b0;
          end else if (!s_r.sleepCfg) begin
            if (!s_r.nmiS2) begin
              s_nxt.st = ipd_pkg::ST_PD_PROT;
              s_nxt.pwr = '0;
            end else begin
              s_nxt.refused = 1'b1;
            end
          end else if (allInactive) begin
            s_nxt.st = ipd_pkg::ST_PD_INT;
            s_nxt.pwr = '0;
            s_nxt.entryLvl = lvl;
            s_nxt.holdCnt = '0;
          end else begin
            s_nxt.refused = 1'b1;
          end
        end
      end
      ipd_pkg::ST_IDLE: begin
        setMask = edgeHit;
        // a good event transfer leaves idle untouched
        if (cpuIn.irqRequest || cpuIn.eventXferFail) begin
          s_nxt.st = ipd_pkg::ST_RUN;
          s_nxt.pwr.cpuRun = 1'b1;
        end
      end
      ipd_pkg::ST_PD_PROT: begin
        // only sys_rst leaves this state
        s_nxt.st = ipd_pkg::ST_PD_PROT;
      end
      ipd_pkg::ST_PD_INT: begin
        // enable bits are not consulted for the wake
        if (|hit) begin
          if (s_r.holdCnt >= HOLD_CYC - 2'h1) begin
            s_nxt.st = ipd_pkg::ST_WAKE_WAIT;
            s_nxt.wakeChan = hit;
            setMask = hit;
            s_nxt.pwr.oscOn = 1'b1;
            s_nxt.pwr.capPullDown = 1'b1;
          end else begin
            s_nxt.holdCnt = s_r.holdCnt + 2'h1;
          end
        end else begin
          s_nxt.holdCnt = '0;
        end
      end
      ipd_pkg::ST_WAKE_WAIT: begin
        // clock hold flop clears once the capacitor has discharged
        if (s_r.capS2) begin
          s_nxt.st = ipd_pkg::ST_RESUME;
          s_nxt.pwr.cpuRun = 1'b1;
          s_nxt.pwr.periphRun = 1'b1;
          s_nxt.pwr.capPullDown = 1'b0;
          s_nxt.stepNext = 1'b1;
        end
      end
      ipd_pkg::ST_RESUME: begin
        setMask = edgeHit;
        s_nxt.st = ipd_pkg::ST_RUN;
        if (|(s_r.wakeChan & s_r.irqEnable)) begin
          s_nxt.st = ipd_pkg::ST_ISR;
          s_nxt.isrCall = 1'b1;
        end
      end
      default: begin
        setMask = edgeHit;
        s_nxt.st = ipd_pkg::ST_RUN;
      end
    endcase
    // pull-up charges the capacitor while sleepCfg is set and it is not being drained
    s_nxt.pwr.capPullUp = s_r.sleepCfg & ~s_nxt.pwr.capPullDown;

    // a write lands only on the edge where pready is seen high
    wr = psel & penable & pwrite & s_r.pready;
    rd = psel & ~penable & ~pwrite;
    if (psel && !penable) begin
      s_nxt.pready = 1'b1;
    end
    if (rd) begin
      if (paddr == `IPD_OFF_EDGE_SEL) begin
        s_nxt.prdata = {16'h0000, s_r.edgeSel};
      end else if (paddr == `IPD_OFF_SYS_CFG) begin
        s_nxt.prdata = 32'(s_r.sleepCfg) << `IPD_SLEEP_CFG_BIT;
      end else if (paddr == `IPD_OFF_CHAN_IRQ) begin
        s_nxt.prdata = {16'h0000, s_r.irqFlag, s_r.irqEnable};
      end else if (paddr == `IPD_OFF_STATUS) begin
        s_nxt.prdata = {24'h000000, s_r.pwr, s_r.st};
      end else begin
        s_nxt.prdata = 32'h00000000;
      end
    end
    s_nxt.irqFlag = s_r.irqFlag;
    if (wr) begin
      if (paddr == `IPD_OFF_EDGE_SEL) begin
        s_nxt.edgeSel = pwdata[15:0];
      end else if (paddr == `IPD_OFF_SYS_CFG) begin
        s_nxt.sleepCfg = pwdata[`IPD_SLEEP_CFG_BIT];
      end else if (paddr == `IPD_OFF_CHAN_IRQ) begin
        s_nxt.irqEnable = pwdata[7:0];
        s_nxt.irqFlag = s_r.irqFlag & ~pwdata[15:8];
      end
    end
    // a new event beats a clear in the same cycle
    s_nxt.irqFlag = s_nxt.irqFlag | setMask;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.st <= ipd_pkg::ST_RUN;
      s_r.edgeSel <= `IPD_RST_EDGE_SEL;
      s_r.sleepCfg <= 1'b0;
      s_r.pwr <= `IPD_RST_PWR;
    end else begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_busDone;
    s_r.st == ipd_pkg::ST_WAIT_BUS && !cpuIn.busBusy;
  endsequence
  sequence s_wakeSeen;
    s_r.st == ipd_pkg::ST_PD_INT && s_nxt.st == ipd_pkg::ST_WAKE_WAIT;
  endsequence

  property p_entryNeedsInstr;
    $rose(s_r.st == ipd_pkg::ST_WAIT_BUS) |->
      $past(cpuIn.idleInstr) || $past(cpuIn.sleepAllInstr);
  endproperty
  a_entryNeedsInstr: assert property (p_entryNeedsInstr)
    else $error("low power entry without an instruction");

  property p_idleCpuOff;
    s_r.st == ipd_pkg::ST_IDLE |-> !s_r.pwr.cpuRun && s_r.pwr.periphRun;
  endproperty
  a_idleCpuOff: assert property (p_idleCpuOff)
    else $error("idle clock enables wrong");

  property p_pdAllOff;
    (s_r.st == ipd_pkg::ST_PD_PROT || s_r.st == ipd_pkg::ST_PD_INT) |->
      !s_r.pwr.cpuRun && !s_r.pwr.periphRun && !s_r.pwr.oscOn;
  endproperty
  a_pdAllOff: assert property (p_pdAllOff)
    else $error("clock running in power down");

  property p_busWait;
    s_r.st == ipd_pkg::ST_WAIT_BUS && cpuIn.busBusy |=>
      s_r.st == ipd_pkg::ST_WAIT_BUS;
  endproperty
  a_busWait: assert property (p_busWait)
    else $error("left bus wait while bus busy");

  property p_readyRefuse;
    s_busDone ##0 (cpuIn.readyEnabled && !cpuIn.readyAckLast) |=>
      entryRefused && s_r.st == ipd_pkg::ST_RUN;
  endproperty
  a_readyRefuse: assert property (p_readyRefuse)
    else $error("entry not refused without ready");

  property p_idleExit;
    s_r.st == ipd_pkg::ST_IDLE && cpuIn.irqRequest |=>
      s_r.st == ipd_pkg::ST_RUN && s_r.pwr.cpuRun;
  endproperty
  a_idleExit: assert property (p_idleExit)
    else $error("idle not left on interrupt");

  property p_protStays;
    s_r.st == ipd_pkg::ST_PD_PROT |=> s_r.st == ipd_pkg::ST_PD_PROT;
  endproperty
  a_protStays: assert property (p_protStays)
    else $error("protected power down left without reset");

  property p_wakePower;
    s_wakeSeen |=> s_r.pwr.oscOn && s_r.pwr.capPullDown &&
      !s_r.pwr.cpuRun ##0 (s_r.irqFlag & s_r.wakeChan) == s_r.wakeChan;
  endproperty
  a_wakePower: assert property (p_wakePower)
    else $error("wake did not start oscillator and pull-down");

  property p_gateUntilCap;
    s_r.st == ipd_pkg::ST_WAKE_WAIT && s_r.capS2 |=>
      stepNext && s_r.pwr.cpuRun ##1 !stepNext;
  endproperty
  a_gateUntilCap: assert property (p_gateUntilCap)
    else $error("clocks not released after capacitor threshold");

  property p_stepBeforeIsr;
    isrCall |-> $past(stepNext);
  endproperty
  a_stepBeforeIsr: assert property (p_stepBeforeIsr)
    else $error("service call without the following instruction");

  property p_protNeedsNmi;
    s_busDone ##0 (entryOk && s_r.pendPd && !s_r.sleepCfg && s_r.nmiS2)
      |=> entryRefused && s_r.st == ipd_pkg::ST_RUN;
  endproperty
  a_protNeedsNmi: assert property (p_protNeedsNmi)
    else $error("protected power down entered with nmi high");

  property p_activePinBlocks;
    s_busDone ##0 (entryOk && s_r.pendPd && s_r.sleepCfg && !allInactive)
      |=> entryRefused && s_r.st == ipd_pkg::ST_RUN;
  endproperty
  a_activePinBlocks: assert property (p_activePinBlocks)
    else $error("interruptible power down entered with a pin active");

  property p_isrWhenEnabled;
    s_r.st == ipd_pkg::ST_RESUME &&
      (s_r.wakeChan & s_r.irqEnable) != 8'h00 |=> isrCall;
  endproperty
  a_isrWhenEnabled: assert property (p_isrWhenEnabled)
    else $error("enabled wake channel not serviced");
endmodule

// ### test/ipd_far_side.sv
// far side model: wake pin levels and delay capacitor discharge
`timescale 1ns/1ps
module ipd_far_side #(
  parameter int CAP_DLY = 20
) (
  input wire logic clk,
  input wire logic [7:0] pinLvl,
  input wire logic capPullDown,
  output logic [7:0] fastWakePin,
  output logic capBelowThr
);
  int capCnt_r = 0;
  // bench holds every level for two or more cycles, past 40 ns here
  assign fastWakePin = pinLvl;
  // pull-up recharges while the pull-down is off; discharge takes a while
  always @(posedge clk) begin
    if (!capPullDown)
      capCnt_r <= 0;
    else if (capCnt_r < CAP_DLY)
      capCnt_r <= capCnt_r + 1;
  end
  assign capBelowThr = (capCnt_r >= CAP_DLY);
endmodule

// ### test/tb_top.sv
// self-checking bench for the idle and power down controller
`timescale 1ns/1ps
`include "ipd_defines.svh"
module tb_top;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, r;
  ipd_pkg::ipd_cpu_t cpu;
  ipd_pkg::ipd_power_t pwr;
  logic nmiPinN, capBelowThr, entryRefused, stepNext, isrCall;
  logic [7:0] pinLvl, fastWakePin, irqFlag;
  logic [31:0] expQ[$];
  int fail_count, comparisons;
  int refCnt, stepCnt, isrCnt;

  ipd_power_ctrl dut_u(.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuIn(cpu),
    .nmiPinN(nmiPinN), .fastWakePin(fastWakePin),
    .capBelowThr(capBelowThr), .pwrOut(pwr), .entryRefused(entryRefused),
    .stepNext(stepNext), .isrCall(isrCall), .irqFlag(irqFlag));
  ipd_far_side far_u(.clk(clk), .pinLvl(pinLvl),
    .capPullDown(pwr.capPullDown), .fastWakePin(fastWakePin),
    .capBelowThr(capBelowThr));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // read results are compared in order of the notes queued by rd
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
      comparisons++;
      if (prdata !== expQ[0]) begin
        fail_count++;
        $display("wrong value prdata at %h expected %h seen %h", paddr,
          expQ[0], prdata);
      end
      void'(expQ.pop_front());
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // one-cycle pulses are counted at the edge that closes them
  always @(posedge clk) begin
    if (entryRefused === 1'b1) refCnt++;
    if (stepNext === 1'b1) stepCnt++;
    if (isrCall === 1'b1) isrCnt++;
    if (psel && penable && pready === 1'b1)
      chk("pslverr", 32'h0, {31'h0, pslverr});
  end

  function automatic logic [31:0] st(logic [4:0] p, logic [2:0] s);
    return {24'h0, p, s};
  endfunction

  task report_and_stop();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task rst();
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready that never comes
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [15:0] a, input logic [31:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task instr(input logic s);
    @(posedge clk);
    cpu.idleInstr <= !s;
    cpu.sleepAllInstr <= s;
    @(posedge clk);
    cpu.idleInstr <= 1'b0;
    cpu.sleepAllInstr <= 1'b0;
  endtask

  // the watchdog catches a wait that never ends
  task waitrun(input logic v);
    while (pwr.cpuRun !== v) begin
      @(posedge clk);
    end
  endtask

  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    cpu = '0;
    nmiPinN = 1'b1;
    pinLvl = 8'h00;
    sys_rst = 1'b1;
    void'($urandom(32'h8708));
    rst();
    rd(`IPD_OFF_EDGE_SEL, 32'h0);
    rd(`IPD_OFF_SYS_CFG, 32'h0);
    rd(`IPD_OFF_STATUS, st(5'h1C, 3'h0));
    rd(16'hF1D0, 32'h0);
    r = $urandom();
    apb(1'b1, `IPD_OFF_EDGE_SEL, {16'h0, r[15:0]});
    rd(`IPD_OFF_EDGE_SEL, {16'h0, r[15:0]});
    cpu.busBusy <= 1'b1;
    instr(1'b0);
    repeat (r[19:16] + 2) @(posedge clk);
    rd(`IPD_OFF_STATUS, st(5'h1C, 3'h1));
    cpu.busBusy <= 1'b0;
    waitrun(1'b0);
    rd(`IPD_OFF_STATUS, st(5'h0C, 3'h2));
    cpu.eventXferOk <= 1'b1;
    rd(`IPD_OFF_STATUS, st(5'h0C, 3'h2));
    cpu.eventXferOk <= 1'b0;
    cpu.eventXferFail <= 1'b1;
    @(posedge clk);
    cpu.eventXferFail <= 1'b0;
    waitrun(1'b1);
    rd(`IPD_OFF_STATUS, st(5'h1C, 3'h0));
    cpu.readyEnabled <= 1'b1;
    instr(1'b0);
    repeat (8) @(posedge clk);
    rd(`IPD_OFF_STATUS, st(5'h1C, 3'h0));
    chk("entryRefused count", 32'h1, refCnt);
    cpu.readyAckLast <= 1'b1;
    instr(1'b0);
    waitrun(1'b0);
    rd(`IPD_OFF_STATUS, st(5'h0C, 3'h2));
    cpu.irqRequest <= 1'b1;
    waitrun(1'b1);
    cpu.irqRequest <= 1'b0;
    rd(`IPD_OFF_STATUS, st(5'h1C, 3'h0));
    // protected power down: nmi pin decides, only reset leaves it
    apb(1'b1, `IPD_OFF_EDGE_SEL, 32'h1);
    instr(1'b1);
    repeat (8) @(posedge clk);
    rd(`IPD_OFF_STATUS, st(5'h1C, 3'h0));
    chk("entryRefused count", 32'h2, refCnt);
    nmiPinN <= 1'b0;
    instr(1'b1);
    waitrun(1'b0);
    rd(`IPD_OFF_STATUS, st(5'h00, 3'h3));
    pinLvl <= 8'h01;
    repeat (10) @(posedge clk);
    rd(`IPD_OFF_STATUS, st(5'h00, 3'h3));
    pinLvl <= 8'h00;
    nmiPinN <= 1'b1;
    rst();
    rd(`IPD_OFF_STATUS, st(5'h1C, 3'h0));
    // interruptible power down, wake pin 0 rising with its enable clear
    apb(1'b1, `IPD_OFF_EDGE_SEL, 32'h1);
    apb(1'b1, `IPD_OFF_SYS_CFG, 32'h20);
    rd(`IPD_OFF_STATUS, st(5'h1D, 3'h0));
    pinLvl <= 8'h01;
    instr(1'b1);
    repeat (8) @(posedge clk);
    rd(`IPD_OFF_STATUS, st(5'h1D, 3'h0));
    chk("entryRefused count", 32'h3, refCnt);
    pinLvl <= 8'h00;
    apb(1'b1, `IPD_OFF_CHAN_IRQ, 32'h100);
    instr(1'b1);
    waitrun(1'b0);
    rd(`IPD_OFF_STATUS, st(5'h01, 3'h4));
    pinLvl <= 8'h01;
    repeat (3) @(posedge clk);
    pinLvl <= 8'h00;
    repeat (6) @(posedge clk);
    rd(`IPD_OFF_STATUS, st(5'h06, 3'h5));
    waitrun(1'b1);
    rd(`IPD_OFF_STATUS, st(5'h1D, 3'h0));
    chk("stepNext count", 32'h1, stepCnt);
    chk("isrCall count", 32'h0, isrCnt);
    rd(`IPD_OFF_CHAN_IRQ, 32'h100);
    apb(1'b1, `IPD_OFF_CHAN_IRQ, 32'h100);
    rd(`IPD_OFF_CHAN_IRQ, 32'h0);
    // second wake with the channel enabled calls the service routine
    apb(1'b1, `IPD_OFF_CHAN_IRQ, 32'h1);
    instr(1'b1);
    waitrun(1'b0);
    rd(`IPD_OFF_STATUS, st(5'h01, 3'h4));
    pinLvl <= 8'h01;
    repeat (3) @(posedge clk);
    pinLvl <= 8'h00;
    waitrun(1'b1);
    rd(`IPD_OFF_STATUS, st(5'h1D, 3'h0));
    chk("stepNext count", 32'h2, stepCnt);
    chk("isrCall count", 32'h1, isrCnt);
    rd(`IPD_OFF_CHAN_IRQ, 32'h101);
    chk("entryRefused count", 32'h3, refCnt);
    report_and_stop();
  end
endmodule
